// ### pkg/mau_pkg.sv
// Purpose: shared constants and types of the memory addressing unit
// Assumes: one instruction-cycle clock, core issues one command per cycle
// Notes: data memory offsets are byte addresses inside the 8-bit space
package mau_pkg;
   // program store geometry
   localparam int PC_W = 13;
   localparam int ROM_WORDS = 8192;
   localparam int ROM_W = 16;
   localparam int PAGE_W = 8;
   localparam int STACK_LEVELS = 8;
   localparam int IRQ_N = 6;

   // fixed program locations
   localparam logic [12:0] VEC_RESET = 13'h0000;
   localparam logic [12:0] VEC_EXT = 13'h0004;
   localparam logic [12:0] VEC_TMR0 = 13'h0008;
   localparam logic [12:0] VEC_TMR1 = 13'h000C;
   localparam logic [12:0] VEC_MULTI = 13'h0010;
   localparam logic [12:0] VEC_CONV = 13'h0014;
   localparam logic [12:0] VEC_TOUCH = 13'h0018;
   localparam logic [4:0] LAST_PAGE = 5'h1F;

   // data memory map
   localparam logic [7:0] ADDR_WINDOW_0 = 8'h00;
   localparam logic [7:0] ADDR_POINTER_0 = 8'h01;
   localparam logic [7:0] ADDR_WINDOW_1 = 8'h02;
   localparam logic [7:0] ADDR_POINTER_1 = 8'h03;
   localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
   localparam logic [7:0] ADDR_PC_LOW = 8'h06;
   localparam logic [7:0] ADDR_TABLE_POINTER = 8'h07;
   localparam logic [7:0] ADDR_TABLE_HIGH = 8'h08;
   localparam logic [7:0] GP_BASE = 8'h40;
   localparam int GP_BYTES = 192;
   localparam logic [7:0] DISP_LAST = 8'h5B;
   localparam int DISP_BYTES = 28;
   localparam int BANK_SELECT_BIT = 0;

   // reset values
   localparam logic [7:0] RST_POINTER = 8'h00;
   localparam logic [7:0] RST_TABLE = 8'h00;
   localparam logic [7:0] RST_READ = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   typedef enum logic [3:0] {
      OP_NOP = 4'b0000,
      OP_FETCH = 4'b0001,
      OP_JUMP = 4'b0010,
      OP_CALL = 4'b0011,
      OP_RET = 4'b0100,
      OP_INTERRUPT_RETURN = 4'b0101,
      OP_TRD_CUR = 4'b0110,
      OP_TRD_LAST = 4'b0111,
      OP_DM_READ = 4'b1000,
      OP_DM_WRITE = 4'b1001,
      OP_BIT_SET = 4'b1010,
      OP_BIT_CLR = 4'b1011,
      OP_INT_POLL = 4'b1100
   } mau_op_t;

   typedef enum logic [0:0] {
      TBL_IDLE = 1'b0,
      TBL_FILL = 1'b1
   } mau_tbl_state_t;

   typedef struct packed {
      mau_op_t op;
      logic [12:0] target;
      logic [7:0] dm_addr;
      logic [7:0] wdata;
      logic [2:0] bit_sel;
   } mau_cmd_t;

   // a data memory reference after indirection
   typedef struct packed {
      logic [7:0] tgt;
      logic bank1;
      logic dead;
   } mau_ref_t;
endpackage

// ### rtl/mau_core.sv
// Purpose: program counter, return stack, table read and data memory map
// Assumes: core issues one command per cycle, ignored while BUSY is high
// Notes: IRQ_REQ bits are request flags already gated by their enables
// Operation
// - after reset the program counter is 000H
// - external interrupt acknowledged branches to 004H
// - timer 0 overflow interrupt branches to 008H
// - timer 1 overflow interrupt branches to 00CH
// - multi-function interrupt branches to 010H
// - converter interrupt branches to 014H
// - touch-key interrupt branches to 018H
// - program store of 8192 words of 16 bits, fetch or table read
// - table address is page bits plus table pointer; last page is all ones
// - table read puts low byte in data memory, rest in table high byte
// - table read takes two cycles
// - eight-level stack, not visible to software
// - call and interrupt push the counter; returns restore it
// - reset leaves the stack empty
// - with stack full, interrupts stay pending until a return pops
// - call with stack full drops the oldest entry
// - unassigned addresses below 40H read as 00H
// - 192 general-purpose bytes at 40H to FFH
// - single bits of data memory can be set and cleared
// - locations 00H and 02H reach the byte named by pointer 0 or 1
// - indirect access aimed at 00H or 02H reads 00H, writes nothing
// - pointer 1 with bank 1 selected reaches display bytes 40H to 5BH
// - 13-bit program counter increments after each fetch
// - only bit 0 of the bank select is stored, other bits read zero
`timescale 1ns/1ps

module mau_core #(
   parameter int STACK_DEPTH = mau_pkg::STACK_LEVELS
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire mau_pkg::mau_cmd_t CMD,
   input wire logic [mau_pkg::IRQ_N-1:0] IRQ_REQ,
   input wire logic PROG_WE,
   input wire logic [mau_pkg::PC_W-1:0] PROG_ADDR,
   input wire logic [mau_pkg::ROM_W-1:0] PROG_DATA,
   output logic [mau_pkg::PC_W-1:0] PC,
   output logic [mau_pkg::ROM_W-1:0] INSTR,
   output logic [7:0] DM_RDATA,
   output logic [mau_pkg::IRQ_N-1:0] IRQ_ACK,
   output logic STACK_FULL,
   output logic BUSY
);
   import mau_pkg::*;

   localparam int SW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
   localparam logic [SW-1:0] TOP_IDX = SW'(STACK_DEPTH - 1);
   localparam logic [SW:0] FULL_CNT = (SW + 1)'(STACK_DEPTH);

   // storage
   logic [ROM_W-1:0] rom [ROM_WORDS];
   logic [7:0] gp_mem [GP_BYTES];
   logic [7:0] disp_mem [DISP_BYTES];
   // return stack lives outside the data map, software cannot reach it
   logic [PC_W-1:0] stack [STACK_DEPTH];

   logic [PC_W-1:0] pc;
   logic [SW-1:0] wr_idx;
   logic [SW:0] depth;
   logic [7:0] mp0;
   logic [7:0] mp1;
   logic bank_bit;
   logic [7:0] table_pointer;
   logic [7:0] table_high_byte;
   mau_tbl_state_t tbl_state;
   logic [ROM_W-1:0] tbl_word;
   logic [7:0] tbl_dest;

   logic go;
   logic [SW-1:0] top_idx;
   logic [SW-1:0] next_wr_idx;
   logic [PC_W-1:0] tbl_addr;
   logic [IRQ_N-1:0] irq_pick;
   logic irq_any;
   logic [PC_W-1:0] irq_vec;
   logic push;
   logic pop;
   logic ack;
   mau_ref_t rd_ref;
   mau_ref_t wr_ref;
   logic [7:0] rd_val;
   logic [7:0] bit_mask;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_reg;
   logic [PC_W-1:0] next_pc;

   // indirection through the two windows
   function automatic mau_ref_t resolve(input logic [7:0] a,
                                        input logic [7:0] p0,
                                        input logic [7:0] p1,
                                        input logic b1);
      mau_ref_t r;
      r.tgt = a;
      r.bank1 = 1'b0;
      r.dead = 1'b0;
      if (a == ADDR_WINDOW_0 || a == ADDR_WINDOW_1) begin
         r.tgt = (a == ADDR_WINDOW_0) ? p0 : p1;
         r.dead = (r.tgt == ADDR_WINDOW_0) || (r.tgt == ADDR_WINDOW_1);
         r.bank1 = (a == ADDR_WINDOW_1) && b1 && (r.tgt >= GP_BASE)
                   && (r.tgt <= DISP_LAST);
      end
      return r;
   endfunction

   function automatic logic [PC_W-1:0] vector_of(input int i);
      logic [PC_W-1:0] v;
      case (i)
         0: v = VEC_EXT;
         1: v = VEC_TMR0;
         2: v = VEC_TMR1;
         3: v = VEC_MULTI;
         4: v = VEC_CONV;
         5: v = VEC_TOUCH;
         default: v = VEC_RESET;
      endcase
      return v;
   endfunction

   // a command offered during the table fill cycle is dropped
   assign go = (CMD.op != OP_NOP) && (tbl_state == TBL_IDLE);
   // ring indices wrap, so a push when full reuses the oldest slot
   assign top_idx = (wr_idx == '0) ? TOP_IDX : wr_idx - 1'b1;
   assign next_wr_idx = (wr_idx == TOP_IDX) ? '0 : wr_idx + 1'b1;

   // table location: page bits of the counter or all ones
   assign tbl_addr = (CMD.op == OP_TRD_LAST) ? {LAST_PAGE, table_pointer}
                     : {pc[PC_W-1:PAGE_W], table_pointer};

   // fixed priority, lowest vector wins
   always_comb begin
      irq_pick = '0;
      irq_vec = VEC_RESET;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (IRQ_REQ[i]) begin
            irq_pick = '0;
            irq_pick[i] = 1'b1;
            irq_vec = vector_of(i);
         end
      end
   end
   assign irq_any = |IRQ_REQ;

   // requests arrive already gated by their enables
   // a full stack blocks the acknowledge, the request stays pending
   assign ack = go && (CMD.op == OP_INT_POLL) && irq_any
                && (depth != FULL_CNT);
   assign push = (go && (CMD.op == OP_CALL)) || ack;
   assign pop = go && ((CMD.op == OP_RET) || (CMD.op == OP_INTERRUPT_RETURN))
                && (depth != '0);

   // read side of data memory
   assign rd_ref = resolve(CMD.dm_addr, mp0, mp1, bank_bit);
   always_comb begin
      rd_val = RST_READ;
      if (rd_ref.dead) begin
         rd_val = RST_READ;
      end else if (rd_ref.tgt >= GP_BASE) begin
         if (rd_ref.bank1) begin
            rd_val = disp_mem[5'(rd_ref.tgt - GP_BASE)];
         end else begin
            rd_val = gp_mem[8'(rd_ref.tgt - GP_BASE)];
         end
      end else begin
         case (rd_ref.tgt)
            ADDR_POINTER_0: rd_val = mp0;
            ADDR_POINTER_1: rd_val = mp1;
            ADDR_BANK_SELECT: rd_val = {7'h00, bank_bit};
            ADDR_PC_LOW: rd_val = pc[7:0];
            ADDR_TABLE_POINTER: rd_val = table_pointer;
            ADDR_TABLE_HIGH: rd_val = table_high_byte;
            default: rd_val = RST_READ;
         endcase
      end
   end

   assign bit_mask = 8'h01 << CMD.bit_sel;

   // one write path shared by stores, bit updates and table fills
   // the table fill owns the port in its second cycle
   always_comb begin
      wr_en = 1'b0;
      wr_addr = CMD.dm_addr;
      wr_data = CMD.wdata;
      if (tbl_state == TBL_FILL) begin
         wr_en = 1'b1;
         wr_addr = tbl_dest;
         wr_data = tbl_word[7:0];
      end else if (go) begin
         case (CMD.op)
            OP_DM_WRITE: wr_en = 1'b1;
            OP_BIT_SET: begin
               wr_en = 1'b1;
               wr_data = rd_val | bit_mask;
            end
            OP_BIT_CLR: begin
               wr_en = 1'b1;
               wr_data = rd_val & ~bit_mask;
            end
            default: wr_en = 1'b0;
         endcase
      end
   end

   assign wr_ref = resolve(wr_addr, mp0, mp1, bank_bit);
   assign wr_reg = wr_en && !wr_ref.dead && (wr_ref.tgt < GP_BASE);

   // program counter
   always_comb begin
      next_pc = pc;
      if (wr_reg && wr_ref.tgt == ADDR_PC_LOW) begin
         next_pc = {pc[PC_W-1:PAGE_W], wr_data};
      end else if (go) begin
         case (CMD.op)
            OP_FETCH: next_pc = pc + 1'b1;
            OP_JUMP, OP_CALL: next_pc = CMD.target;
            OP_RET, OP_INTERRUPT_RETURN: begin
               if (depth != '0) begin
                  next_pc = stack[top_idx];
               end
            end
            OP_INT_POLL: begin
               if (ack) begin
                  next_pc = irq_vec;
               end
            end
            default: next_pc = pc;
         endcase
      end
   end

   // PC is a copy of pc so the port comes straight from a flip-flop
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pc <= VEC_RESET;
         PC <= VEC_RESET;
      end else begin
         pc <= next_pc;
         PC <= next_pc;
      end
   end

   // return stack as a ring: a push when full overwrites the oldest
   // slots carry no reset, depth alone tells which ones are live
   always_ff @(posedge REF_CLK) begin
      if (push) begin
         stack[wr_idx] <= pc;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_idx <= '0;
         depth <= '0;
         STACK_FULL <= 1'b0;
      end else if (push) begin
         wr_idx <= next_wr_idx;
         if (depth != FULL_CNT) begin
            depth <= depth + 1'b1;
         end
         // full once this push fills the last free level
         STACK_FULL <= 1'b1;
         if (depth < FULL_CNT - 1'b1) begin
            STACK_FULL <= 1'b0;
         end
         // depth saturates, oldest slot is reused
      end else if (pop) begin
         wr_idx <= top_idx;
         depth <= depth - 1'b1;
         STACK_FULL <= 1'b0;
      end
   end

   // program store load port and fetch
   // the load port is the only writer; fetch and table reads only read
   always_ff @(posedge REF_CLK) begin
      if (PROG_WE) begin
         rom[PROG_ADDR] <= PROG_DATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         INSTR <= RST_WORD;
      end else if (go && CMD.op == OP_FETCH) begin
         INSTR <= rom[pc];
      end
   end

   // table read: word captured now, stored next cycle
   // the page bits come from the counter as it stands at the command
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tbl_state <= TBL_IDLE;
         tbl_word <= RST_WORD;
         tbl_dest <= RST_POINTER;
         table_high_byte <= RST_TABLE;
         BUSY <= 1'b0;
      end else begin
         case (tbl_state)
            TBL_IDLE: begin
               if (go && (CMD.op == OP_TRD_CUR || CMD.op == OP_TRD_LAST)) begin
                  tbl_word <= rom[tbl_addr];
                  tbl_dest <= CMD.dm_addr;
                  tbl_state <= TBL_FILL;
                  BUSY <= 1'b1;
               end
            end
            TBL_FILL: begin
               table_high_byte <= tbl_word[15:8];
               tbl_state <= TBL_IDLE;
               BUSY <= 1'b0;
            end
            default: begin
               tbl_state <= TBL_IDLE;
               BUSY <= 1'b0;
            end
         endcase
      end
   end

   // special registers; table high byte ignores stores
   // only bit 0 of the bank select is kept, the rest read back as zero
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         mp0 <= RST_POINTER;
         mp1 <= RST_POINTER;
         bank_bit <= 1'b0;
         table_pointer <= RST_TABLE;
      end else if (wr_reg) begin
         case (wr_ref.tgt)
            ADDR_POINTER_0: mp0 <= wr_data;
            ADDR_POINTER_1: mp1 <= wr_data;
            ADDR_BANK_SELECT: bank_bit <= wr_data[BANK_SELECT_BIT];
            ADDR_TABLE_POINTER: table_pointer <= wr_data;
            default: ;
         endcase
      end
   end

   // general-purpose and display bytes
   // display bytes are reached only through window 1 with bank 1 set
   always_ff @(posedge REF_CLK) begin
      if (wr_en && !wr_ref.dead && wr_ref.tgt >= GP_BASE) begin
         if (wr_ref.bank1) begin
            disp_mem[5'(wr_ref.tgt - GP_BASE)] <= wr_data;
         end else begin
            gp_mem[8'(wr_ref.tgt - GP_BASE)] <= wr_data;
         end
      end
   end

   // read data and acknowledge pulses
   // read data holds until the next data read, an acknowledge one cycle
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         DM_RDATA <= RST_READ;
         IRQ_ACK <= '0;
      end else begin
         if (go && CMD.op == OP_DM_READ) begin
            DM_RDATA <= rd_val;
         end
         IRQ_ACK <= ack ? irq_pick : '0;
      end
   end

endmodule // mau_core

// ### tb/mau_core_model.sv
// Purpose: stand-in for the instruction core driving the command port
// Assumes: the bench hands over a command at a falling edge and a no-op at the next one
// Notes: offers a no-op while the unit reports the table fill cycle
`timescale 1ns/1ps
module mau_core_model (
   input wire logic busy,
   input wire mau_pkg::mau_cmd_t req,
   output mau_pkg::mau_cmd_t cmd
);
   import mau_pkg::*;
   // a command during the fill cycle would be dropped silently
   always_comb begin
      cmd = req;
      if (busy) begin
         cmd.op = OP_NOP;
      end
   end
endmodule // mau_core_model

// ### tb/mau_core_monitor.sv
// Purpose: port checker for the memory addressing unit
// Assumes: one clock, commands taken only while BUSY is low
// Notes: a level counter mirrors the return stack depth
`timescale 1ns/1ps
module mau_core_chk #(
   parameter int STACK_DEPTH = 8
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire mau_pkg::mau_cmd_t CMD,
   input wire logic [mau_pkg::IRQ_N-1:0] IRQ_REQ,
   input wire logic PROG_WE,
   input wire logic [mau_pkg::PC_W-1:0] PROG_ADDR,
   input wire logic [mau_pkg::ROM_W-1:0] PROG_DATA,
   input wire logic [mau_pkg::PC_W-1:0] PC,
   input wire logic [mau_pkg::ROM_W-1:0] INSTR,
   input wire logic [7:0] DM_RDATA,
   input wire logic [mau_pkg::IRQ_N-1:0] IRQ_ACK,
   input wire logic STACK_FULL,
   input wire logic BUSY
);
   import mau_pkg::*;
   mau_op_t op;
   logic take;
   logic push;
   logic pop;
   int lvl;
   assign op = CMD.op;
   assign take = !BUSY && op != OP_NOP;
   assign push = take && (op == OP_CALL || op == OP_INT_POLL && IRQ_REQ != '0);
   assign pop = take && (op == OP_RET || op == OP_INTERRUPT_RETURN);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         lvl <= 0;
      end else if (push && lvl < STACK_DEPTH) begin
         lvl <= lvl + 1;
      end else if (pop && lvl != 0) begin
         lvl <= lvl - 1;
      end
   end
   AST_FETCH_INC: assert property (take && op == OP_FETCH
      |=> PC == $past(PC) + 13'h0001) else $error("fetch step");
   AST_CALL_JUMP: assert property (take && (op == OP_CALL ||
      op == OP_JUMP) |=> PC == $past(CMD.target)) else $error("branch");
   AST_ACK_PRIO: assert property (take && op == OP_INT_POLL &&
      !STACK_FULL |=> IRQ_ACK == ($past(IRQ_REQ) & (~$past(IRQ_REQ)
      + 6'h01))) else $error("ack order");
   AST_VECTOR: assert property (IRQ_ACK != '0 |->
      PC == {8'h00, |IRQ_ACK[5:3], IRQ_ACK[1] | IRQ_ACK[2] | IRQ_ACK[5],
      IRQ_ACK[0] | IRQ_ACK[2] | IRQ_ACK[4], 2'b00}) else $error("vector");
   AST_FULL_BLOCK: assert property (STACK_FULL
      |=> IRQ_ACK == '0) else $error("ack while full");
   AST_TBL_BUSY: assert property (take && (op == OP_TRD_CUR ||
      op == OP_TRD_LAST) |=> BUSY ##1 !BUSY) else $error("table busy");
   AST_BUSY_HOLD: assert property (BUSY
      |=> !BUSY && $stable(INSTR)) else $error("busy hold");
   AST_UNASSIGNED: assert property (take && op == OP_DM_READ &&
      CMD.dm_addr > ADDR_TABLE_HIGH && CMD.dm_addr < GP_BASE
      |=> DM_RDATA == 8'h00) else $error("unassigned read");
   AST_BANK_BIT: assert property (take && op == OP_DM_READ &&
      CMD.dm_addr == ADDR_BANK_SELECT |=> DM_RDATA[7:1] == 7'h00)
      else $error("bank bits");
   AST_STACK_LEVEL: assert property (
      STACK_FULL == (lvl == STACK_DEPTH)) else $error("stack level");
   cover property (IRQ_ACK != '0);
   cover property (take && op == OP_CALL && STACK_FULL);
   cover property (BUSY);
   cover property (take && op == OP_RET && STACK_FULL);
endmodule // mau_core_chk

bind mau_core mau_core_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (
   .REF_CLK(REF_CLK), .RSTN(RSTN), .CMD(CMD), .IRQ_REQ(IRQ_REQ),
   .PROG_WE(PROG_WE), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
   .PC(PC), .INSTR(INSTR), .DM_RDATA(DM_RDATA), .IRQ_ACK(IRQ_ACK),
   .STACK_FULL(STACK_FULL), .BUSY(BUSY));

// ### tb/testbench.sv
// Purpose: self-checking bench for the memory addressing unit
// Assumes: 20 MHz clock, inputs move on the falling edge
// Notes: table rows walk the data memory map
`timescale 1ns/1ps
module testbench;
   import mau_pkg::*;
   typedef struct packed {
      logic [7:0] wa;
      logic [7:0] wd;
      logic [7:0] ra;
      logic [7:0] ex;
   } mau_row_t;
   mau_row_t rows [13] = '{
      '{8'h41, 8'h5A, 8'h41, 8'h5A},
      '{8'h01, 8'h41, 8'h00, 8'h5A},
      '{8'h00, 8'hC3, 8'h41, 8'hC3},
      '{8'h03, 8'h00, 8'h02, 8'h00},
      '{8'h02, 8'h77, 8'h41, 8'hC3},
      '{8'h04, 8'hFF, 8'h04, 8'h01},
      '{8'h03, 8'h41, 8'h03, 8'h41},
      '{8'h02, 8'h99, 8'h02, 8'h99},
      '{8'h01, 8'h41, 8'h00, 8'hC3},
      '{8'h09, 8'hAB, 8'h09, 8'h00},
      '{8'h08, 8'h12, 8'h08, 8'h00},
      '{8'hFF, 8'hE1, 8'hFF, 8'hE1},
      '{8'h04, 8'h00, 8'h02, 8'hC3}
   };
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   mau_cmd_t req = '0;
   mau_cmd_t cmd;
   logic [5:0] irq = '0;
   logic pwe = 1'b0;
   logic [12:0] pa = '0;
   logic [15:0] pd = '0;
   logic [12:0] pc;
   logic [15:0] instr;
   logic [7:0] rd;
   logic [5:0] ack;
   logic full;
   logic busy;
   int fails = 0;
   int check_count = 0;
   always #25 clk = ~clk;
   mau_core i_dut (.REF_CLK(clk), .RSTN(rst_n), .CMD(cmd), .IRQ_REQ(irq),
      .PROG_WE(pwe), .PROG_ADDR(pa), .PROG_DATA(pd), .PC(pc),
      .INSTR(instr), .DM_RDATA(rd), .IRQ_ACK(ack), .STACK_FULL(full),
      .BUSY(busy));
   mau_core_model i_core (.busy(busy), .req(req), .cmd(cmd));
   task automatic chk(input string n, input logic [15:0] e,
         input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_pc(input logic [12:0] e);
      chk("pc", 16'(e), 16'(pc));
   endtask
   task automatic run(input mau_op_t o, input logic [12:0] t,
         input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
      @(negedge clk);
      req <= '{o, t, a, d, b};
      @(negedge clk);
      req.op <= OP_NOP;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      run(OP_DM_READ, 0, a, 0, 0);
      chk("dm_rdata", 16'(e), 16'(rd));
   endtask
   task automatic prog(input logic [12:0] a, input logic [15:0] d);
      @(negedge clk);
      pwe <= 1'b1;
      pa <= a;
      pd <= d;
      @(negedge clk);
      pwe <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      chk_pc(13'h0000);
      rst_n <= 1'b1;
      prog(13'h0000, 16'hA1B2);
      prog(13'h0034, 16'h1357);
      prog(13'h1F34, 16'h2468);
      foreach (rows[i]) begin
         run(OP_DM_WRITE, 0, rows[i].wa, rows[i].wd, 0);
         rdchk(rows[i].ra, rows[i].ex);
      end
      $display("test data map done");
      run(OP_FETCH, 0, 0, 0, 0);
      chk("instr", 16'hA1B2, instr);
      chk_pc(13'h0001);
      run(OP_DM_WRITE, 0, ADDR_TABLE_POINTER, 8'h34, 0);
      rdchk(ADDR_TABLE_POINTER, 8'h34);
      run(OP_TRD_CUR, 0, 8'h50, 0, 0);
      chk("busy", 16'h0001, 16'(busy));
      rdchk(8'h50, 8'h57);
      rdchk(ADDR_TABLE_HIGH, 8'h13);
      run(OP_TRD_LAST, 0, 8'h51, 0, 0);
      rdchk(8'h51, 8'h68);
      rdchk(ADDR_TABLE_HIGH, 8'h24);
      run(OP_DM_WRITE, 0, 8'h60, 8'h81, 0);
      run(OP_BIT_SET, 0, 8'h60, 0, 3'd5);
      rdchk(8'h60, 8'hA1);
      run(OP_BIT_CLR, 0, 8'h60, 0, 3'd7);
      rdchk(8'h60, 8'h21);
      $display("test table and bits done");
      run(OP_JUMP, 13'h0100, 0, 0, 0);
      for (int i = 0; i < IRQ_N; i++) begin
         irq <= 6'h3F << i;
         run(OP_INT_POLL, 0, 0, 0, 0);
         chk("irq_ack", 16'(6'h01 << i), 16'(ack));
         chk_pc(13'(4 * i + 4));
         run(OP_INTERRUPT_RETURN, 0, 0, 0, 0);
         chk_pc(13'h0100);
      end
      $display("test vectors done");
      irq <= 6'h01;
      for (int i = 0; i < 9; i++) begin
         run(OP_CALL, 13'(13'h0200 + i), 0, 0, 0);
      end
      chk("stack_full", 16'h0001, 16'(full));
      run(OP_INT_POLL, 0, 0, 0, 0);
      chk("irq_ack", 16'h0000, 16'(ack));
      chk_pc(13'h0208);
      for (int i = 7; i >= 0; i--) begin
         run(OP_RET, 0, 0, 0, 0);
         chk_pc(13'(13'h0200 + i));
      end
      run(OP_INT_POLL, 0, 0, 0, 0);
      chk("irq_ack", 16'h0001, 16'(ack));
      $display("test stack done");
      @(negedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      chk_pc(13'h0000);
      rst_n <= 1'b1;
      run(OP_RET, 0, 0, 0, 0);
      chk_pc(13'h0000);
      run(OP_DM_WRITE, 0, ADDR_PC_LOW, 8'h42, 0);
      chk_pc(13'h0042);
      rdchk(ADDR_PC_LOW, 8'h42);
      $display("test second reset done");
      close_out();
   end
endmodule // testbench
